// *** core/eewr_slave.sv ***
// Two-wire EEPROM slave front end: bus decode, acknowledge, page buffer,
// write FIFO and the timed array write.
// Assumes scl and sda are already synchronous to mclk and filtered.
`timescale 1ns/10ps
`include "eewr_consts.svh"

module eewr_fifo #(
   parameter int W = 16,
   parameter int DEPTH = `EEWR_FIFO_DEPTH
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] count;
   } eewr_fifo_st_t;

   eewr_fifo_st_t st;
   eewr_fifo_st_t next_st;
   logic [W-1:0] mem [0:DEPTH-1];
   logic push;
   logic pop;

   assign in_ready = (st.count != (AW+1)'(DEPTH));
   assign out_valid = (st.count != '0);
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem[st.rp];

   always_comb begin
      next_st = st;
      if (push) begin
         next_st.wp = st.wp + 1'b1;
      end
      if (pop) begin
         next_st.rp = st.rp + 1'b1;
      end
      case ({push, pop})
         2'b10: next_st.count = st.count + 1'b1;
         2'b01: next_st.count = st.count - 1'b1;
         default: next_st.count = st.count;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
      if (push) begin
         mem[st.wp] <= in_data;
      end
   end
endmodule

module eewr_slave #(
   parameter int WRITE_CYCLES = `EEWR_TWC_MS * (`EEWR_CLK_HZ / `EEWR_MS_PER_S),
   parameter int FIFO_DEPTH = `EEWR_FIFO_DEPTH
) (
   input wire logic mclk,
   input wire logic srst,
   input wire eewr_pkg::eewr_pins_t pins,
   output logic sda_out,
   output logic sda_oe,
   input wire logic chip_select_in_0,
   input wire logic chip_select_in_1,
   input wire logic chip_select_in_2,
   input wire logic cascadable,
   output logic bus_idle,
   output logic write_busy,
   input wire logic [7:0] peek_addr,
   output logic [7:0] peek_data
);
   import eewr_pkg::*;

   localparam int TW = $clog2(WRITE_CYCLES + 1);

   typedef struct packed {
      eewr_state_t state;
      logic scl_q;
      logic sda_q;
      logic idle;
      logic [7:0] shreg;
      logic [3:0] bit_cnt;
      logic ack_phase;
      logic drive;
      logic [7:0] ptr;
      logic [15:0][7:0] page;
      logic [15:0] pvalid;
      logic got_data;
      logic committing;
      logic [3:0] cidx;
      logic [TW-1:0] timer;
      logic [4:0] div;
      logic [7:0] peek;
   } eewr_top_st_t;

   eewr_top_st_t st;
   eewr_top_st_t next_st;
   logic [7:0] mem [0:255];

   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic byte_done;
   logic busy;
   logic ctrl_match;
   logic [3:0] idx_mask;
   logic [3:0] buf_idx;
   logic [7:0] commit_addr;
   logic push;
   logic push_ready;
   eewr_wr_t push_data;
   logic drain_valid;
   logic drain_ready;
   eewr_wr_t drain_data;
   logic mem_we;

   // Both lines sampled on mclk; a condition needs the clock high on both samples
   assign scl_rise = pins.scl & ~st.scl_q;
   assign scl_fall = ~pins.scl & st.scl_q;
   // Start only from an idle-high data line with clock held high
   assign start_det = pins.scl & st.scl_q & st.sda_q & ~pins.sda;
   assign stop_det = pins.scl & st.scl_q & ~st.sda_q & pins.sda;
   // Byte ends on the falling clock after the eighth bit
   assign byte_done = scl_fall & ~st.ack_phase & (st.bit_cnt == `EEWR_BITS_PER_BYTE);

   assign busy = st.committing | (st.timer != '0) | drain_valid;
   assign idx_mask = cascadable ? `EEWR_BIG_MASK : `EEWR_SMALL_MASK;
   assign buf_idx = st.ptr[3:0] & idx_mask;
   // Commit address keeps the page base and takes the buffer slot
   assign commit_addr = (st.ptr & ~{4'h0, idx_mask}) | {4'h0, st.cidx & idx_mask};

   assign ctrl_match = (st.shreg[7:4] == `EEWR_TYPE_CODE)
      & (~cascadable
         | (st.shreg[3:1] == {chip_select_in_2, chip_select_in_1, chip_select_in_0}))
      & ~busy;

   assign push = st.committing & st.pvalid[st.cidx] & ((st.cidx & idx_mask) == st.cidx);
   assign push_data = '{addr: commit_addr, data: st.page[st.cidx]};

   // Slow drain: one write per 32 cycles; only a FIFO_DEPTH below 16 can fill and hold back the commit walk
   assign drain_ready = (st.div == `EEWR_DRAIN_TICK);
   assign mem_we = drain_valid & drain_ready & ~drain_data.addr[`EEWR_PROT_BIT];

   assign sda_out = 1'b0;
   assign sda_oe = st.drive;
   assign bus_idle = st.idle;
   assign write_busy = busy;
   assign peek_data = st.peek;

   eewr_fifo #(
      .W($bits(eewr_wr_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .mclk(mclk),
      .srst(srst),
      .in_valid(push),
      .in_ready(push_ready),
      .in_data(push_data),
      .out_valid(drain_valid),
      .out_ready(drain_ready),
      .out_data(drain_data)
   );

   always_comb begin
      next_st = st;
      next_st.scl_q = pins.scl;
      next_st.sda_q = pins.sda;
      next_st.idle = pins.scl & pins.sda;
      next_st.div = st.div + 1'b1;
      next_st.peek = mem[peek_addr];
      if (st.timer != '0) begin
         next_st.timer = st.timer - 1'b1;
      end

      // Walk the page buffer; a full FIFO stalls the walk
      if (st.committing && (push_ready || !push)) begin
         next_st.cidx = st.cidx + 1'b1;
         if (st.cidx == `EEWR_LAST_IDX) begin
            next_st.committing = 1'b0;
         end
      end

      if (scl_rise && st.state != EEWR_IDLE && !st.ack_phase
          && st.bit_cnt != `EEWR_BITS_PER_BYTE) begin
         next_st.shreg = {st.shreg[6:0], pins.sda};
         next_st.bit_cnt = st.bit_cnt + 1'b1;
      end

      if (scl_fall && st.ack_phase) begin
         // Release after the ninth pulse; reads leave the line high
         next_st.ack_phase = 1'b0;
         next_st.drive = 1'b0;
      end else if (byte_done) begin
         next_st.ack_phase = 1'b1;
         next_st.bit_cnt = '0;
         case (st.state)
            EEWR_CTRL: begin
               if (ctrl_match) begin
                  next_st.drive = 1'b1;
                  next_st.state = st.shreg[0] ? EEWR_READ : EEWR_WADDR;
               end else begin
                  next_st.state = EEWR_IGNORE;
               end
            end
            EEWR_WADDR: begin
               next_st.ptr = st.shreg;
               next_st.pvalid = '0;
               next_st.drive = 1'b1;
               next_st.state = EEWR_WDATA;
            end
            EEWR_WDATA: begin
               // Slot by pointer: a later byte overwrites the oldest
               next_st.page[buf_idx] = st.shreg;
               next_st.pvalid[buf_idx] = 1'b1;
               next_st.got_data = 1'b1;
               // Low bits only; pointer stays in this page
               next_st.ptr = (st.ptr & ~{4'h0, idx_mask})
                  | {4'h0, (st.ptr[3:0] + 4'h1) & idx_mask};
               next_st.drive = 1'b1;
            end
            default: begin
               next_st.drive = 1'b0;
            end
         endcase
      end

      if (start_det) begin
         // Pointer kept so a following read can use it
         next_st.state = EEWR_CTRL;
         next_st.bit_cnt = '0;
         next_st.ack_phase = 1'b0;
         next_st.drive = 1'b0;
         next_st.got_data = 1'b0;
      end else if (stop_det) begin
         if (st.state == EEWR_WDATA && st.got_data) begin
            next_st.committing = 1'b1;
            next_st.cidx = '0;
            next_st.timer = TW'(WRITE_CYCLES);
         end
         next_st.state = EEWR_IDLE;
         next_st.ack_phase = 1'b0;
         next_st.drive = 1'b0;
         next_st.got_data = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
      if (mem_we) begin
         mem[drain_data.addr] <= drain_data.data;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   a_busy_no_ack: assert property (busy |-> !sda_oe)
      else $error("acknowledge driven during write cycle");

   a_ctrl_ack: assert property (byte_done && st.state == EEWR_CTRL && ctrl_match
      |=> sda_oe && st.ack_phase)
      else $error("matching control byte not acknowledged");

   a_bad_code_nack: assert property (byte_done && st.state == EEWR_CTRL
      && st.shreg[7:4] != `EEWR_TYPE_CODE |=> !sda_oe ##1 st.state == EEWR_IGNORE
      || start_det || stop_det)
      else $error("wrong type code acknowledged");

   a_ack_held: assert property (sda_oe && !scl_fall && !start_det && !stop_det
      |=> sda_oe)
      else $error("acknowledge released before clock fell");

   a_stop_ends: assert property (stop_det |=> st.state == EEWR_IDLE && !sda_oe)
      else $error("stop did not end transaction");

   a_start_restart: assert property (start_det |=> st.state == EEWR_CTRL
      && st.bit_cnt == 4'h0 && st.ptr == $past(st.ptr))
      else $error("start did not restart control reception");

   a_protect_hi: assert property (mem_we |-> !drain_data.addr[`EEWR_PROT_BIT])
      else $error("write reached protected half");

   a_page_wrap: assert property (byte_done && st.state == EEWR_WDATA && cascadable
      |=> st.ptr[7:4] == $past(st.ptr[7:4]))
      else $error("page pointer upper bits changed");

   a_stop_timer: assert property (stop_det && st.state == EEWR_WDATA && st.got_data
      |=> st.timer == TW'(WRITE_CYCLES) && st.committing)
      else $error("write cycle not started on stop");

   a_timer_bound: assert property (st.timer <= TW'(WRITE_CYCLES))
      else $error("write timer above limit");

   a_read_release: assert property (st.state == EEWR_READ && !st.ack_phase
      |-> !sda_oe)
      else $error("data line held during read");

   a_idle_flag: assert property (!$past(srst) |-> bus_idle == $past(pins.scl && pins.sda))
      else $error("bus idle flag does not follow the lines");

   a_ack_after_byte: assert property ($rose(sda_oe) |-> $past(byte_done))
      else $error("acknowledge driven outside the ninth pulse");

   a_ignore_silent: assert property (st.state == EEWR_IGNORE |-> !sda_oe)
      else $error("data line driven after a refused control byte");

   a_small_page: assert property (byte_done && st.state == EEWR_WDATA && !cascadable
      |=> st.ptr[7:3] == $past(st.ptr[7:3]))
      else $error("small page pointer upper bits changed");

   a_bit_limit: assert property (st.bit_cnt <= `EEWR_BITS_PER_BYTE)
      else $error("bit counter above byte length");

   c_page_commit: cover property (push && !push_ready);
   c_busy_poll: cover property (byte_done && st.state == EEWR_CTRL && busy);
   c_read_ack: cover property (byte_done && st.state == EEWR_CTRL && ctrl_match
      && st.shreg[0]);
   c_protected_drop: cover property (drain_valid && drain_ready
      && drain_data.addr[`EEWR_PROT_BIT]);
endmodule

// *** core/eewr_consts.svh ***
// Constants for the two-wire EEPROM write front end.
// Assumes one 10 MHz clock and bus pins already synchronous to it.
`ifndef EEWR_CONSTS_SVH
`define EEWR_CONSTS_SVH

`define EEWR_TYPE_CODE 4'hA
`define EEWR_BITS_PER_BYTE 4'h8
`define EEWR_TWC_MS 5
`define EEWR_CLK_HZ 10000000
`define EEWR_MS_PER_S 1000
`define EEWR_PROT_BIT 7
`define EEWR_SMALL_MASK 4'h7
`define EEWR_BIG_MASK 4'hF
`define EEWR_LAST_IDX 4'hF
`define EEWR_DRAIN_TICK 5'h1F
`define EEWR_FIFO_DEPTH 16

`endif

// *** core/eewr_pkg.sv ***
// Types shared by the EEPROM write front end.
// Assumes the constants header is included by the users of these types.
package eewr_pkg;

   typedef enum logic [2:0] {
      EEWR_IDLE   = 3'b000,
      EEWR_CTRL   = 3'b001,
      EEWR_WADDR  = 3'b010,
      EEWR_WDATA  = 3'b011,
      EEWR_READ   = 3'b100,
      EEWR_IGNORE = 3'b101
   } eewr_state_t;

   typedef struct packed {
      logic scl;
      logic sda;
   } eewr_pins_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } eewr_wr_t;

   typedef struct packed {
      logic [3:0] chip_select;
      logic cascadable;
   } eewr_cfg_t;

endpackage

// *** sim/eewr_master.sv ***
// Two-wire bus master model: drives the serial clock and its side of data.
// Assumes an open-drain data wire with a pull-up; the slave only pulls low.
`timescale 1ns/10ps

module eewr_master (
   input wire logic mclk,
   input wire logic sda_oe,
   output wire eewr_pkg::eewr_pins_t pins
);
   import eewr_pkg::*;
   logic scl = 1'b1;
   logic drv = 1'b1;
   // Wire level: pull-up unless a party pulls low
   assign pins = {scl, drv & ~sda_oe};

   task automatic wt(input int n);
      repeat (n) begin
         @(posedge mclk);
         #1;
      end
   endtask

   task automatic start();
      drv = 1'b1;
      wt(2);
      scl = 1'b1;
      wt(4);
      drv = 1'b0;
      wt(4);
      scl = 1'b0;
      wt(2);
   endtask

   task automatic stop();
      drv = 1'b0;
      wt(2);
      scl = 1'b1;
      wt(4);
      drv = 1'b1;
      wt(4);
   endtask

   task automatic byte_tx(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         drv = b[i];
         wt(2);
         scl = 1'b1;
         wt(4);
         scl = 1'b0;
         wt(2);
      end
      // Released so the slave can answer on the ninth pulse
      drv = 1'b1;
      wt(1);
      scl = 1'b1;
      wt(2);
      ack = ~pins.sda;
      wt(2);
      scl = 1'b0;
      wt(2);
   endtask
endmodule

// *** sim/tb.sv ***
// Self-checking bench for the EEPROM write front end.
// Assumes the master model drives the bus; write time shortened to 200 cycles.
`timescale 1ns/10ps

module tb;
   import eewr_pkg::*;
   typedef struct packed {
      logic [7:0] ctrl;
      logic casc;
      logic [2:0] cs;
      logic ack;
   } eewr_row_t;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic casc;
   logic [2:0] cs;
   logic [7:0] peek_addr;
   wire eewr_pins_t pins;
   logic sda_out, sda_oe, bus_idle, write_busy, ack;
   logic [7:0] peek_data;
   logic [7:0] em [256];
   int errors = 0;
   int samples_checked = 0;
   eewr_row_t rows [8] = '{{8'hA0, 1'b0, 3'h0, 1'b1}, {8'hA1, 1'b0, 3'h0, 1'b1},
      {8'hAE, 1'b0, 3'h5, 1'b1}, {8'hB0, 1'b0, 3'h0, 1'b0}, {8'h20, 1'b0, 3'h0, 1'b0},
      {8'hAA, 1'b1, 3'h5, 1'b1}, {8'hAC, 1'b1, 3'h5, 1'b0}, {8'hA7, 1'b1, 3'h3, 1'b1}};

   eewr_slave #(.WRITE_CYCLES(200), .FIFO_DEPTH(16)) eewr_slave_i (.mclk(mclk),
      .srst(srst), .pins(pins), .sda_out(sda_out), .sda_oe(sda_oe),
      .chip_select_in_0(cs[0]), .chip_select_in_1(cs[1]), .chip_select_in_2(cs[2]),
      .cascadable(casc), .bus_idle(bus_idle), .write_busy(write_busy),
      .peek_addr(peek_addr), .peek_data(peek_data));
   eewr_master eewr_master_i (.mclk(mclk), .sda_oe(sda_oe), .pins(pins));

   initial begin
      forever #50 mclk = ~mclk;
   end

   task automatic chk1(input string n, input logic e, input logic g);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic end_sim();
      $display("checked %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic tx(input logic [7:0] b, input logic e);
      eewr_master_i.byte_tx(b, ack);
      chk1("ack", e, ack);
   endtask

   task automatic wait_idle();
      for (int i = 0; i < 3000 && write_busy !== 1'b0; i++)
         eewr_master_i.wt(1);
      if (write_busy !== 1'b0) begin
         errors++;
         end_sim();
      end
   endtask

   task automatic page(input logic [7:0] a, input int n, input logic [7:0] d,
      input logic [7:0] m);
      logic [7:0] s;
      eewr_master_i.start();
      tx(8'hA0 | {cs, 1'b0}, 1'b1);
      tx(a, 1'b1);
      for (int i = 0; i < n; i++) begin
         s = (a & ~m) | ((a + 8'(i)) & m);
         em[s] = d + 8'(i);
         tx(d + 8'(i), 1'b1);
      end
      chk1("write_busy", 1'b0, write_busy);
      eewr_master_i.stop();
      chk1("write_busy", 1'b1, write_busy);
   endtask

   task automatic verify(input logic [7:0] a, input logic [7:0] m);
      for (int j = 0; j <= int'(m); j++) begin
         peek_addr = (a & ~m) | 8'(j);
         eewr_master_i.wt(2);
         chk8("peek_data", em[peek_addr], peek_data);
      end
   endtask

   initial begin
      casc = 1'b0;
      cs = 3'h0;
      peek_addr = 8'h00;
      repeat (11) @(posedge mclk);
      #1;
      chk1("sda_oe", 1'b0, sda_oe);
      chk1("sda_out", 1'b0, sda_out);
      chk1("write_busy", 1'b0, write_busy);
      chk8("peek_data", 8'h00, peek_data);
      @(posedge mclk);
      #1;
      srst = 1'b0;
      eewr_master_i.wt(3);
      chk1("bus_idle", 1'b1, bus_idle);
      foreach (rows[k]) begin
         casc = rows[k].casc;
         cs = rows[k].cs;
         eewr_master_i.start();
         tx(rows[k].ctrl, rows[k].ack);
         eewr_master_i.stop();
      end
      casc = 1'b0;
      cs = 3'h0;
      page(8'h10, 1, 8'h5A, 8'h00);
      // Polling while the timed write runs must go unanswered
      eewr_master_i.start();
      tx(8'hA0, 1'b0);
      eewr_master_i.stop();
      wait_idle();
      verify(8'h10, 8'h00);
      page(8'h25, 9, 8'h60, 8'h07);
      wait_idle();
      verify(8'h25, 8'h07);
      casc = 1'b1;
      page(8'h3E, 17, 8'h80, 8'h0F);
      wait_idle();
      verify(8'h3E, 8'h0F);
      casc = 1'b0;
      page(8'h85, 1, 8'h11, 8'h00);
      wait_idle();
      peek_addr = 8'h85;
      eewr_master_i.wt(2);
      chk1("guarded", 1'b1, peek_data !== 8'h11);
      eewr_master_i.start();
      tx(8'hA0, 1'b1);
      tx(8'h50, 1'b1);
      eewr_master_i.start();
      tx(8'hA0, 1'b1);
      tx(8'h51, 1'b1);
      tx(8'h33, 1'b1);
      eewr_master_i.stop();
      wait_idle();
      peek_addr = 8'h51;
      eewr_master_i.wt(2);
      chk8("peek_data", 8'h33, peek_data);
      // Reset inside a timed write: busy drops, acknowledges come back
      page(8'h60, 1, 8'h77, 8'h00);
      srst = 1'b1;
      eewr_master_i.wt(2);
      chk1("write_busy", 1'b0, write_busy);
      chk1("bus_idle", 1'b0, bus_idle);
      chk1("sda_oe", 1'b0, sda_oe);
      srst = 1'b0;
      eewr_master_i.wt(3);
      chk1("bus_idle", 1'b1, bus_idle);
      eewr_master_i.start();
      tx(8'hA0, 1'b1);
      eewr_master_i.stop();
      end_sim();
   end
endmodule
